//--- hw/cbr_pkg.sv
// cpu board restart, reset and timing support: shared constants and carriers
// assumes a 50 MHz system clock and a byte-wide processor io/memory bus
package cbr_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int MOTOR_ON_DELAY_MS = 1000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  localparam int MS_PER_SEC = 1000;
  localparam int OFF_128_S = 128;
  localparam int OFF_64_S = 64;
  localparam int OFF_32_S = 32;

  // ==========================================================
  // memory map
  localparam logic [15:0] PROM_BASE = 16'hF800;
  localparam int PROM_BYTES = 2048;
  localparam int PROM_AW = 11;
  localparam logic [7:0] RAM_ON_PORT = 8'hD0;
  localparam logic [3:0] RAM_ON_PORT_HI = 4'hD;
  localparam logic [3:0] FDC_PORT_HI = 4'h8;

  // ==========================================================
  // clock divider taps (16 MHz master)
  localparam int DIV_8M = 0;
  localparam int DIV_4M = 1;
  localparam int DIV_1M = 3;
  localparam int DIV_500K = 4;

  // jumper selection, one-hot, pin pair order 5-6, 3-4, 1-2
  localparam logic [2:0] SEL_128 = 3'b100;
  localparam logic [2:0] SEL_64 = 3'b010;
  localparam logic [2:0] SEL_32 = 3'b001;

  typedef enum logic [1:0] {
    CBR_MAP_RESTART,
    CBR_MAP_RAM_PROM,
    CBR_MAP_RAM_ONLY
  } cbr_map_e;

  // processor bus cycle carrier
  typedef struct packed {
    logic mem_rd;
    logic io_wr;
    logic io_rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cbr_bus_s;

  // reset distribution carrier
  typedef struct packed {
    logic cpu;
    logic video;
    logic fdc;
    logic apu;
  } cbr_rst_s;

endpackage : cbr_pkg

//--- hw/cbr_board.sv
// cpu board restart overlay, reset fan-out, clock divider and disk motor timer
// assumes bus strobes are one-cycle pulses synchronous to clk_sys
`timescale 1ns/1ps

module cbr_board
  import cbr_pkg::*;
#(
  parameter int MOTOR_ON_MS = MOTOR_ON_DELAY_MS, // motor spin-up, milliseconds
  parameter int TICK_CLKS = TICK_CYCLES,         // cycles per millisecond tick
  parameter int BAUD_W = 8                       // baud divisor width
) (
  input wire logic clk_sys,                // 50 MHz system clock
  input wire logic srst,                   // power-on reset, active high
  input wire logic board_reset_button,     // push button, active high
  input wire logic kbd_reset_req,          // keyboard reset via video side
  input wire logic power_fail,             // power detector, active high
  input wire logic sw_fdc_reset,           // software fdc reset bit
  input wire logic sw_apu_reset,           // software apu reset bit
  input wire cbr_bus_s bus,                // processor bus cycle
  input wire logic prom_remove,            // software request for 65K ram map
  input wire logic [BAUD_W-1:0] list_baud, // list port divisor load value
  input wire logic list_baud_wr,           // list divisor strobe
  input wire logic clk_osc16,              // 16 MHz master, sampled level
  input wire logic clk_baud,               // 4.9152 MHz baud crystal, sampled level
  input wire logic head_load_req,          // controller head load command
  input wire logic [2:0] motor_off_delay_select, // jumper pairs 5-6,3-4,1-2
  output cbr_rst_s rst_out,                // distributed resets
  output logic ram_en,                     // ram answers this read
  output logic prom_en,                    // prom answers this read
  output logic [PROM_AW-1:0] prom_addr,    // prom byte index
  output logic [BAUD_W-1:0] modem_baud,    // modem divisor setting
  output logic [3:0] sys_clks,             // 8,4,1,0.5 MHz taps
  output logic cpu_clk,                    // processor clock
  output logic modem_baud_clk,             // modem baud tick
  output logic list_baud_clk,              // list baud tick
  output logic head_load,                  // head load to drive
  output logic motor_on,                   // drive motor enable
  output logic drive_sel_en                // drives may be selected
);

  // ==========================================================
  // reset distribution
  cbr_rst_s rst_r, rst_nxt;
  logic main_rst;

  // power fail is the same path as the button
  always_comb begin
    main_rst = srst | board_reset_button | power_fail | kbd_reset_req;
    rst_nxt.cpu = main_rst;
    rst_nxt.video = srst | board_reset_button | power_fail;
    rst_nxt.fdc = main_rst | sw_fdc_reset;
    rst_nxt.apu = main_rst | sw_apu_reset;
  end

  // registered fan-out; srst feeds every branch, so no reset term is needed here
  always_ff @(posedge clk_sys) begin
    rst_r <= rst_nxt;
  end
  // resets leave straight from the registers, one cycle after their cause
  assign rst_out = rst_r;

  // ==========================================================
  // memory map overlay
  cbr_map_e map_r, map_nxt;
  logic [BAUD_W-1:0] modem_baud_r, modem_baud_nxt;
  logic ram_en_r, ram_en_nxt, prom_en_r, prom_en_nxt;
  logic [PROM_AW-1:0] prom_addr_r, prom_addr_nxt;
  logic ram_on_wr, in_prom;

  // write to the D0H block both enables ram and latches the modem baud
  always_comb begin
    ram_on_wr = bus.io_wr && (bus.addr[7:4] == RAM_ON_PORT_HI);
    in_prom = bus.addr >= PROM_BASE;
    map_nxt = map_r;
    modem_baud_nxt = modem_baud_r;
    if (ram_on_wr) begin
      modem_baud_nxt = bus.wdata[BAUD_W-1:0];
      if (map_r == CBR_MAP_RESTART) begin
        map_nxt = CBR_MAP_RAM_PROM;
      end
    end
    if (prom_remove && map_nxt != CBR_MAP_RESTART) begin
      map_nxt = CBR_MAP_RAM_ONLY;
    end
    if (main_rst) begin
      map_nxt = CBR_MAP_RESTART;
    end
    ram_en_nxt = 1'b0;
    prom_en_nxt = 1'b0;
    case (map_r)
      CBR_MAP_RESTART: prom_en_nxt = bus.mem_rd;
      CBR_MAP_RAM_PROM: begin
        prom_en_nxt = bus.mem_rd && in_prom;
        ram_en_nxt = bus.mem_rd && !in_prom;
      end
      CBR_MAP_RAM_ONLY: ram_en_nxt = bus.mem_rd;
      default: prom_en_nxt = bus.mem_rd;
    endcase
    // prom image mirrors through the map in restart mode
    prom_addr_nxt = bus.addr[PROM_AW-1:0];
  end

  // map state and read selects; selects lag the strobe by one cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      map_r <= CBR_MAP_RESTART;
      modem_baud_r <= '0;
      ram_en_r <= 1'b0;
      prom_en_r <= 1'b0;
      prom_addr_r <= '0;
    end else begin
      map_r <= map_nxt;
      modem_baud_r <= modem_baud_nxt;
      ram_en_r <= ram_en_nxt;
      prom_en_r <= prom_en_nxt;
      prom_addr_r <= prom_addr_nxt;
    end
  end
  // select outputs come straight from the registers
  assign ram_en = ram_en_r;
  assign prom_en = prom_en_r;
  assign prom_addr = prom_addr_r;
  assign modem_baud = modem_baud_r;

  // ==========================================================
  // system clock divider on sampled 16 MHz edges
  logic osc_d_r, osc_d_nxt;
  logic [4:0] div_r, div_nxt;
  logic [3:0] taps_r, taps_nxt;

  // counting sampled rising edges; 16 MHz is only ~3x below clk_sys,
  // so output edges carry one-cycle jitter
  always_comb begin
    osc_d_nxt = clk_osc16;
    div_nxt = div_r;
    if (clk_osc16 && !osc_d_r) begin
      div_nxt = div_r + 5'd1;
    end
    taps_nxt = {div_r[DIV_500K], div_r[DIV_1M], div_r[DIV_4M], div_r[DIV_8M]};
  end

  // divider registers; edge memory starts at the oscillator idle level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      osc_d_r <= 1'b0;
      div_r <= '0;
      taps_r <= '0;
    end else begin
      osc_d_r <= osc_d_nxt;
      div_r <= div_nxt;
      taps_r <= taps_nxt;
    end
  end
  // tap order reversed so bit 3 carries the fastest clock
  assign sys_clks = {taps_r[0], taps_r[1], taps_r[2], taps_r[3]};
  assign cpu_clk = taps_r[1];

  // ==========================================================
  // baud dividers on sampled crystal edges
  logic xtal_d_r, xtal_d_nxt;
  logic [BAUD_W-1:0] list_div_r, list_div_nxt, mcnt_r, mcnt_nxt, lcnt_r, lcnt_nxt;
  logic mclk_r, mclk_nxt, lclk_r, lclk_nxt, xtal_rise;

  // each divider toggles its output when its count reaches the divisor
  always_comb begin
    xtal_d_nxt = clk_baud;
    xtal_rise = clk_baud && !xtal_d_r;
    list_div_nxt = list_baud_wr ? list_baud : list_div_r;
    mcnt_nxt = mcnt_r;
    lcnt_nxt = lcnt_r;
    mclk_nxt = mclk_r;
    lclk_nxt = lclk_r;
    if (xtal_rise) begin
      if (mcnt_r >= modem_baud_r) begin
        mcnt_nxt = '0;
        mclk_nxt = !mclk_r;
      end else begin
        mcnt_nxt = mcnt_r + 1'b1;
      end
      if (lcnt_r >= list_div_r) begin
        lcnt_nxt = '0;
        lclk_nxt = !lclk_r;
      end else begin
        lcnt_nxt = lcnt_r + 1'b1;
      end
    end
  end

  // baud divider registers; divisors keep their value until the next load
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      xtal_d_r <= 1'b0;
      list_div_r <= '0;
      mcnt_r <= '0;
      lcnt_r <= '0;
      mclk_r <= 1'b0;
      lclk_r <= 1'b0;
    end else begin
      xtal_d_r <= xtal_d_nxt;
      list_div_r <= list_div_nxt;
      mcnt_r <= mcnt_nxt;
      lcnt_r <= lcnt_nxt;
      mclk_r <= mclk_nxt;
      lclk_r <= lclk_nxt;
    end
  end
  // a divisor change takes effect at once: the next crystal rise compares the count against the new value
  assign modem_baud_clk = mclk_r;
  assign list_baud_clk = lclk_r;

  // ==========================================================
  // disk motor timer, millisecond tick shared by both delays
  localparam int TW = $clog2(TICK_CLKS + 1);
  localparam int MSW = 18; // holds 128 s in ms
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic [MSW-1:0] idle_ms_r, idle_ms_nxt, spin_ms_r, spin_ms_nxt, off_ms;
  logic motor_r, motor_nxt, hl_r, hl_nxt, tick, fdc_acc, off_en;

  // jumper decode; all open leaves the motor running forever
  always_comb begin
    off_en = 1'b1;
    case (motor_off_delay_select)
      SEL_128: off_ms = MSW'(OFF_128_S * MS_PER_SEC);
      SEL_64: off_ms = MSW'(OFF_64_S * MS_PER_SEC);
      SEL_32: off_ms = MSW'(OFF_32_S * MS_PER_SEC);
      default: begin
        off_ms = '0;
        off_en = 1'b0;
      end
    endcase
  end

  // head load waits out spin-up when the motor starts from off or reaches its idle turn-off
  always_comb begin
    fdc_acc = (bus.io_wr || bus.io_rd) && (bus.addr[7:4] == FDC_PORT_HI);
    tick = (tick_cnt_r == TW'(TICK_CLKS - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
    motor_nxt = motor_r;
    idle_ms_nxt = idle_ms_r;
    spin_ms_nxt = spin_ms_r;
    if (tick && motor_r && idle_ms_r != '1) begin
      idle_ms_nxt = idle_ms_r + 1'b1;
    end
    if (tick && motor_r && spin_ms_r < MSW'(MOTOR_ON_MS)) begin
      spin_ms_nxt = spin_ms_r + 1'b1;
    end
    if (motor_r && off_en && idle_ms_r >= off_ms) begin
      motor_nxt = 1'b0;
      spin_ms_nxt = '0;
    end
    if (fdc_acc || head_load_req) begin
      idle_ms_nxt = '0;
      motor_nxt = 1'b1;
      if (!motor_r) begin
        spin_ms_nxt = '0;
      end
    end
    hl_nxt = head_load_req && motor_r && spin_ms_r >= MSW'(MOTOR_ON_MS);
    if (rst_r.fdc) begin
      motor_nxt = 1'b0;
      idle_ms_nxt = '0;
      spin_ms_nxt = '0;
      hl_nxt = 1'b0;
    end
  end

  // timer registers; idle count saturates rather than wrapping back to zero
  // so a never-off jumper setting cannot turn into a late turn-off
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tick_cnt_r <= '0;
      idle_ms_r <= '0;
      spin_ms_r <= '0;
      motor_r <= 1'b0;
      hl_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      idle_ms_r <= idle_ms_nxt;
      spin_ms_r <= spin_ms_nxt;
      motor_r <= motor_nxt;
      hl_r <= hl_nxt;
    end
  end
  // motor and drive select share one register, so they always move together
  assign motor_on = motor_r;
  assign drive_sel_en = motor_r;
  assign head_load = hl_r;

endmodule : cbr_board

//--- verif/cbr_board_monitor.sv
// checker for the cpu board support block
// sees only the ports of cbr_board; attached by the bind at the foot
`timescale 1ns/1ps
module cbr_board_monitor
  import cbr_pkg::*;
#(
  parameter int MOTOR_ON_MS = 3,
  parameter int TICK_CLKS = 10,
  parameter int BAUD_W = 8
) (
  input wire logic clk_sys, // clock
  input wire logic srst, // sync reset
  input wire logic board_reset_button, // button
  input wire logic kbd_reset_req, // keyboard reset
  input wire logic power_fail, // power detector
  input wire logic sw_fdc_reset, // sw fdc reset
  input wire logic sw_apu_reset, // sw apu reset
  input wire cbr_bus_s bus, // bus cycle
  input wire cbr_rst_s rst_out, // resets out
  input wire logic ram_en, // ram select
  input wire logic prom_en, // prom select
  input wire logic [PROM_AW-1:0] prom_addr, // prom index
  input wire logic [BAUD_W-1:0] modem_baud, // modem divisor
  input wire logic [3:0] sys_clks, // clock taps
  input wire logic cpu_clk, // cpu clock
  input wire logic head_load, // head load
  input wire logic motor_on // motor enable
);
  // ==========================================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // no reset source active, so bus effects are not overridden
  logic quiet;
  assign quiet = !(board_reset_button | kbd_reset_req | power_fail | sw_fdc_reset | sw_apu_reset);

  button_reset_a:
  assert property (board_reset_button |=> rst_out.cpu && rst_out.video) else $error("button reset");
  kbd_reset_a:
  assert property (kbd_reset_req && !board_reset_button && !power_fail
    |=> rst_out.cpu && !rst_out.video) else $error("keyboard reset");
  power_reset_a:
  assert property (power_fail |=> rst_out.cpu && rst_out.video) else $error("power reset");
  soft_reset_a:
  assert property ((sw_fdc_reset || sw_apu_reset) && !board_reset_button && !kbd_reset_req
    && !power_fail |=> !rst_out.cpu && !rst_out.video && rst_out.fdc == $past(sw_fdc_reset)
    && rst_out.apu == $past(sw_apu_reset)) else $error("software reset");
  restart_map_a:
  assert property (board_reset_button ##1 (!board_reset_button && bus.mem_rd)
    |=> prom_en && !ram_en) else $error("restart map");
  one_answer_a:
  assert property (bus.mem_rd |=> (ram_en ^ prom_en) && prom_addr == $past(bus.addr[10:0]))
    else $error("read select");
  baud_load_a:
  assert property (bus.io_wr && bus.addr[7:4] == 4'hD && quiet
    |=> modem_baud == $past(bus.wdata)) else $error("modem baud load");
  cpu_clock_a:
  assert property (cpu_clk == sys_clks[2]) else $error("cpu clock tap");
  fdc_motor_a:
  assert property ((bus.io_wr || bus.io_rd) && bus.addr[7:4] == 4'h8 && quiet
    |=> motor_on) else $error("motor on access");
  spin_up_a:
  assert property ($rose(motor_on) |-> !head_load [*8]) else $error("head load early");
endmodule : cbr_board_monitor

bind cbr_board cbr_board_monitor #(.MOTOR_ON_MS(MOTOR_ON_MS), .TICK_CLKS(TICK_CLKS),
  .BAUD_W(BAUD_W)) cbr_board_monitor_i (.clk_sys, .srst, .board_reset_button,
  .kbd_reset_req, .power_fail, .sw_fdc_reset, .sw_apu_reset, .bus, .rst_out, .ram_en,
  .prom_en, .prom_addr, .modem_baud, .sys_clks, .cpu_clk, .head_load, .motor_on);

//--- verif/cbr_host_model.sv
// host processor bus model: one-cycle strobes for memory and io cycles
// assumes the bench calls cyc from one process only
`timescale 1ns/1ps
module cbr_host_model
  import cbr_pkg::*;
(
  input wire logic clk_sys, // system clock
  output cbr_bus_s bus // processor bus cycle
);
  // ==========================================================
  // bus cycles
  initial bus = '0;
  // kind is {mem_rd,io_wr,io_rd}; released lines show the inverse, not stale data
  task automatic cyc(input logic [2:0] kind, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    bus = {kind, a, d};
    @(negedge clk_sys);
    bus = {3'b000, ~a, ~d};
  endtask : cyc
endmodule : cbr_host_model

//--- verif/cpu_board_restart_reset_timing_tb_top.sv
// testbench for the cpu board support block
// assumes a one-cycle tick, so the 32 s motor turn-off fits inside the run
`timescale 1ns/1ps
module cpu_board_restart_reset_timing_tb_top
  import cbr_pkg::*;
;
  // ==========================================================
  // signals and instances
  logic clk_sys = 0, srst = 1, prom_remove = 0, list_baud_wr = 0, head_load_req = 0;
  logic clk_osc16 = 0, clk_baud = 0;
  logic [7:0] list_baud = 8'h01;
  logic [2:0] motor_off_delay_select = SEL_32;
  logic [4:0] rsrc = '0;
  wire logic board_reset_button = rsrc[4], kbd_reset_req = rsrc[3], power_fail = rsrc[2];
  wire logic sw_fdc_reset = rsrc[1], sw_apu_reset = rsrc[0];
  wire cbr_bus_s bus;
  cbr_rst_s rst_out;
  logic ram_en, prom_en, cpu_clk, modem_baud_clk, list_baud_clk, head_load, motor_on;
  logic drive_sel_en;
  logic [10:0] prom_addr;
  logic [7:0] modem_baud;
  logic [3:0] sys_clks;
  int bad_count = 0, check_count = 0, cycles = 0, n;
  cbr_host_model cbr_host_model_i (.clk_sys, .bus);
  cbr_board #(.MOTOR_ON_MS(10), .TICK_CLKS(1), .BAUD_W(8)) cbr_board_i (.clk_sys, .srst,
    .board_reset_button, .kbd_reset_req, .power_fail, .sw_fdc_reset, .sw_apu_reset, .bus,
    .prom_remove, .list_baud, .list_baud_wr, .clk_osc16, .clk_baud, .head_load_req,
    .motor_off_delay_select, .rst_out, .ram_en, .prom_en, .prom_addr, .modem_baud,
    .sys_clks, .cpu_clk, .modem_baud_clk, .list_baud_clk, .head_load, .motor_on,
    .drive_sel_en);

  // clock and sampled oscillators, one osc and crystal rise per two cycles
  always #10 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    clk_osc16 <= ~clk_osc16;
    clk_baud <= ~clk_baud;
  end
  // hang guard, above the roughly 65,000 cycles the run needs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 70000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========================================================
  // compare tasks
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_in(input string nm, input int lo, input int hi, input int g);
    check_count++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_in
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // ==========================================================
  // scenarios
  task automatic t_restart();
    cbr_host_model_i.cyc(3'b100, 16'h0100, 8'h00);
    chk("prom_en", 1, prom_en);
    chk("prom_addr", 16'h0100, prom_addr);
    @(negedge clk_sys) prom_remove = 1;
    @(negedge clk_sys) prom_remove = 0;
    cbr_host_model_i.cyc(3'b100, 16'h0100, 8'h00);
    chk("ram_en", 0, ram_en);
  endtask : t_restart
  task automatic t_resets();
    logic [4:0] src [5] = '{5'b10000, 5'b01000, 5'b00100, 5'b00010, 5'b00001};
    logic [3:0] ex [5] = '{4'b1111, 4'b1011, 4'b1111, 4'b0010, 4'b0001};
    for (int i = 0; i < 5; i++) begin
      @(negedge clk_sys) rsrc = src[i];
      @(negedge clk_sys) chk("rst_out", ex[i], rst_out);
      rsrc = '0;
    end
  endtask : t_resets
  task automatic t_ram_on();
    cbr_host_model_i.cyc(3'b010, 16'h00D0, 8'h03);
    chk("modem_baud", 16'h0003, modem_baud);
    cbr_host_model_i.cyc(3'b100, 16'hF7FF, 8'h00);
    chk("ram_en", 1, ram_en);
    cbr_host_model_i.cyc(3'b100, 16'hF800, 8'h00);
    chk("prom_en", 1, prom_en);
    chk("prom_addr", 16'h0000, prom_addr);
    @(negedge clk_sys) prom_remove = 1;
    @(negedge clk_sys) prom_remove = 0;
    cbr_host_model_i.cyc(3'b100, 16'hFFFF, 8'h00);
    chk("ram_en", 1, ram_en);
    @(negedge clk_sys) rsrc = 5'b10000;
    fork
      cbr_host_model_i.cyc(3'b100, 16'h0100, 8'h00);
      @(negedge clk_sys) rsrc = '0;
    join
    chk("prom_en", 1, prom_en);
    chk("ram_en", 0, ram_en);
  endtask : t_ram_on
  task automatic t_clocks();
    int cnt [6] = '{0, 0, 0, 0, 0, 0};
    int ex [6] = '{64, 32, 8, 16, 64, 128};
    logic [5:0] pv, cu;
    @(negedge clk_sys) list_baud_wr = 1;
    @(negedge clk_sys) list_baud_wr = 0;
    pv = {sys_clks, modem_baud_clk, list_baud_clk};
    repeat (256) begin
      @(negedge clk_sys);
      cu = {sys_clks, modem_baud_clk, list_baud_clk};
      for (int j = 0; j < 6; j++) if (cu[j] !== pv[j]) cnt[j]++;
      pv = cu;
    end
    for (int j = 0; j < 6; j++) chk_in("clock toggles", ex[j] - 1, ex[j] + 1, cnt[j]);
  endtask : t_clocks
  task automatic t_motor();
    @(negedge clk_sys) head_load_req = 1;
    @(negedge clk_sys) chk("motor_on", 1, motor_on);
    for (n = 1; head_load !== 1 && n < 60; n++) @(negedge clk_sys);
    chk_in("spin up cycles", 10, 13, n);
    @(negedge clk_sys) head_load_req = 0;
    @(negedge clk_sys) head_load_req = 1;
    for (n = 0; head_load !== 1 && n < 10; n++) @(negedge clk_sys);
    chk_in("warm head load", 0, 3, n);
    head_load_req = 0;
    @(negedge clk_sys) rsrc = 5'b00010;
    @(negedge clk_sys) rsrc = '0;
    @(negedge clk_sys) chk("motor_on", 0, motor_on);
    cbr_host_model_i.cyc(3'b001, 16'h0085, 8'h00);
    chk("motor_on", 1, motor_on);
  endtask : t_motor
  task automatic t_motor_off();
    for (n = 0; motor_on === 1 && n < 33000; n++) @(negedge clk_sys);
    chk_in("off delay cycles", OFF_32_S * MS_PER_SEC, OFF_32_S * MS_PER_SEC + 3, n);
    chk("drive_sel_en", 0, drive_sel_en);
    motor_off_delay_select = 3'b000;
    cbr_host_model_i.cyc(3'b010, 16'h0080, 8'h00);
    repeat (OFF_32_S * MS_PER_SEC + 100) @(negedge clk_sys);
    chk("motor_on", 1, motor_on);
    motor_off_delay_select = SEL_128;
    @(negedge clk_sys) motor_off_delay_select = SEL_64;
    @(negedge clk_sys) chk("motor_on", 1, motor_on);
    motor_off_delay_select = SEL_32;
    repeat (2) @(negedge clk_sys);
    chk("motor_on", 0, motor_on);
    chk("drive_sel_en", 0, drive_sel_en);
  endtask : t_motor_off

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(negedge clk_sys);
    srst = 0;
    repeat (2) @(negedge clk_sys);
    t_restart();
    t_resets();
    t_ram_on();
    t_clocks();
    t_motor();
    t_motor_off();
    summarize();
  end
endmodule : cpu_board_restart_reset_timing_tb_top
